// ### rtl/tcc_timer.sv
// module: 16-bit capture/compare timer with filtered event inputs
// Contract
// - accept level after four agreeing samples
// - 16-bit counter, free-running or interval
// - capture mode: event 0 edge copies counter
// - event 1 to capture A, 4 to B
// - compare mode: equality raises compare interrupt
// - prescale codes 0-5 divide 4..256
// - select bits choose free, compare-clear, capture-clear
// - count enable 0 stops, holds zero
// - after enable: 0000 then 0001
// - rewriting enable 1 does not restart
// - control bits 6,5 read zero
// - writes to compare, reads selected storage
// - compare mode removes event 0 interrupt
// - compare clear: period is compare plus one
// - capture clear zeroes counter at edge
// - free mode: FFFF overflow interrupt, wrap
// - two edge-mode registers, fixed zero bits
// - two sampling registers, fixed zero bits in B only
// - reset clears control, edge, sampling registers
// - reset zeroes counter; captures left undefined
// - compare and event 0 share vector
`timescale 1ns/1ps
module tcc_timer #(
	parameter int CNT_W = 16,   // main counter width
	parameter int DIV_W = 8     // divider width
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [15:0] sfr_addr,      // register address
	input  wire logic        sfr_wr,        // write strobe, one cycle
	input  wire logic [15:0] sfr_wdata,     // write data
	output logic      [15:0] sfr_rdata,     // read data of sfr_addr, one cycle late
	input  wire logic        event_input_0, // event pin 0
	input  wire logic        event_input_1, // event pin 1
	input  wire logic        event_input_4, // event pin 4
	output logic             vec0_irq,      // compare match or event 0, shared
	output logic             event1_irq,    // event 1 edge
	output logic             event4_irq,    // event 4 edge
	output logic             overflow_irq   // overflow_irq pulse
);
	// ==================================================================
	// decode helpers
	function automatic logic [DIV_W-1:0] presc_mask(input logic [2:0] code);
		logic [DIV_W-1:0] m;
		m = '0;
		case (code)
			3'h0:    m = tcc_pkg::PRM_DIV4;
			3'h1:    m = tcc_pkg::PRM_DIV8;
			3'h2:    m = tcc_pkg::PRM_DIV16;
			3'h3:    m = tcc_pkg::PRM_DIV32;
			3'h4:    m = tcc_pkg::PRM_DIV64;
			3'h5:    m = tcc_pkg::PRM_DIV256;
			default: m = '0; // prohibited codes
		endcase
		return m;
	endfunction : presc_mask

	function automatic logic [DIV_W-1:0] smp_mask(input logic [1:0] code);
		logic [DIV_W-1:0] m;
		m = '0;
		case (code)
			2'h0:    m = tcc_pkg::PRM_DIV4;
			2'h1:    m = tcc_pkg::PRM_DIV16;
			2'h2:    m = tcc_pkg::PRM_DIV64;
			default: m = tcc_pkg::PRM_DIV256;
		endcase
		return m;
	endfunction : smp_mask

	// edge of a filtered level that the mode calls valid
	function automatic logic edge_hit(input logic [1:0] mode, input logic now_l,
	                                  input logic old_l);
		logic rise;
		logic fall;
		rise = now_l & ~old_l;
		fall = ~now_l & old_l;
		if (mode == tcc_pkg::EDGE_FALL) begin
			edge_hit = fall;
		end else if (mode == tcc_pkg::EDGE_RISE) begin
			edge_hit = rise;
		end else begin
			edge_hit = rise | fall;
		end
	endfunction : edge_hit

	// ==================================================================
	// registers
	logic [7:0]       ctl_r;        // counter_control_reg
	logic [7:0]       edge_a_r;     // edge_mode_reg_a
	logic [7:0]       edge_b_r;     // edge_mode_reg_b
	logic [7:0]       smp_a_r;      // sampling_ctrl_reg_a
	logic [7:0]       smp_b_r;      // sampling_ctrl_reg_b
	logic [CNT_W-1:0] count_r;      // main_counter
	logic [CNT_W-1:0] cmp_r;        // compare storage
	logic [CNT_W-1:0] capcmp_r;     // capture storage of capture_compare_reg
	logic [CNT_W-1:0] cap_a_r;      // capture_reg_a
	logic [CNT_W-1:0] cap_b_r;      // capture_reg_b
	logic [DIV_W-1:0] pdiv_r;       // count prescaler, held at 0 while stopped
	logic [DIV_W-1:0] sdiv_r;       // sampling divider, free running
	logic             start_pend_r; // first count clock after enable holds 0
	logic             match_hold_r; // remembered compare match
	logic             eq_r;         // previous compare equality
	logic             full_r;       // previous FFFF state
	logic [2:0]       lvl_old_r;    // previous filtered levels 0,1,4
	logic [15:0]      rdata_r;
	logic             vec0_r;
	logic             ev1_r;
	logic             ev4_r;
	logic             ovf_r;

	// ==================================================================
	// control decode
	wire       ce      = ctl_r[tcc_pkg::CTL_CE_BIT];
	wire       ccm     = ctl_r[tcc_pkg::CTL_CCM_BIT];
	wire       clr     = ctl_r[tcc_pkg::CTL_CLR_BIT];
	wire [2:0] prm     = ctl_r[tcc_pkg::CTL_PRM_LSB +: 3];
	wire       wr_ctl  = sfr_wr && (sfr_addr == tcc_pkg::OFF_CTL);
	wire       wr_cmp  = sfr_wr && (sfr_addr == tcc_pkg::OFF_CAPCMP);
	wire       wr_ea   = sfr_wr && (sfr_addr == tcc_pkg::OFF_EDGE_A);
	wire       wr_eb   = sfr_wr && (sfr_addr == tcc_pkg::OFF_EDGE_B);
	wire       wr_sa   = sfr_wr && (sfr_addr == tcc_pkg::OFF_SMP_A);
	wire       wr_sb   = sfr_wr && (sfr_addr == tcc_pkg::OFF_SMP_B);
	wire       ce_new  = sfr_wdata[tcc_pkg::CTL_CE_BIT];
	// only an enable going 0 to 1 arms the start; a repeated 1 is ignored
	wire       arm     = wr_ctl && ce_new && !ce;

	// ==================================================================
	// clock enables
	wire [DIV_W-1:0] pm   = presc_mask(prm);
	wire       count_tick = ce && (pm != '0) && ((pdiv_r & pm) == pm);
	wire [DIV_W-1:0] sm0  = smp_mask(smp_a_r[tcc_pkg::SMP_EV0_LSB +: 2]);
	wire [DIV_W-1:0] sm1  = smp_mask(smp_a_r[tcc_pkg::SMP_EV1_LSB +: 2]);
	wire [DIV_W-1:0] sm4  = smp_mask(smp_b_r[tcc_pkg::SMP_EV4_LSB +: 2]);
	wire       smp_en0    = (sdiv_r & sm0) == sm0;
	wire       smp_en1    = (sdiv_r & sm1) == sm1;
	wire       smp_en4    = (sdiv_r & sm4) == sm4;

	// ==================================================================
	// filtered inputs and edges
	logic [2:0] lvl; // filtered levels of event 0, 1, 4

	tcc_sampler u_smp0 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  (event_input_0),
		.smp_en  (smp_en0),
		.level   (lvl[0])
	);
	tcc_sampler u_smp1 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  (event_input_1),
		.smp_en  (smp_en1),
		.level   (lvl[1])
	);
	tcc_sampler u_smp4 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  (event_input_4),
		.smp_en  (smp_en4),
		.level   (lvl[2])
	);

	wire edge0 = edge_hit(edge_a_r[tcc_pkg::EDGE_EV0_LSB +: 2], lvl[0], lvl_old_r[0]);
	wire edge1 = edge_hit(edge_a_r[tcc_pkg::EDGE_EV1_LSB +: 2], lvl[1], lvl_old_r[1]);
	wire edge4 = edge_hit(edge_b_r[tcc_pkg::EDGE_EV4_LSB +: 2], lvl[2], lvl_old_r[2]);

	// ==================================================================
	// mode decode and events
	wire cmp_clr_mode = ccm && clr;
	wire cap_clr_mode = !ccm && clr;
	wire cap_clear    = ce && cap_clr_mode && edge0;
	wire eq_now       = ccm && (count_r == cmp_r);
	wire match_pulse  = eq_now && !eq_r;
	wire full_now     = ce && !clr && (count_r == tcc_pkg::COUNT_MAX);
	wire ovf_pulse    = full_now && !full_r;

	// ==================================================================
	// counter next value
	logic [CNT_W-1:0] count_nxt;
	logic             match_hold_nxt;
	logic             start_pend_nxt;

	always_comb begin
		count_nxt = count_r;
		if (!ce) begin
			count_nxt = '0;
		end else if (cap_clear) begin
			count_nxt = '0;
		end else if (count_tick) begin
			if (start_pend_r || match_hold_r) begin
				count_nxt = '0;
			end else begin
				count_nxt = count_r + 1'b1;
			end
		end
	end

	// match memory: set wins over the clear at the same tick
	always_comb begin
		match_hold_nxt = match_hold_r;
		if (!ce) begin
			match_hold_nxt = 1'b0;
		end else if (cmp_clr_mode && match_pulse) begin
			match_hold_nxt = 1'b1;
		end else if (count_tick) begin
			match_hold_nxt = 1'b0;
		end
	end

	always_comb begin
		start_pend_nxt = start_pend_r;
		if (arm) begin
			start_pend_nxt = 1'b1;
		end else if (!ce || count_tick) begin
			start_pend_nxt = 1'b0;
		end
	end

	// ==================================================================
	// read selection; compare_select_bit alone chooses which capture_compare_reg storage shows
	wire [15:0] capcmp_view = ccm ? cmp_r : capcmp_r;
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000; // unmapped reads return zero
		if (sfr_addr == tcc_pkg::OFF_CTL) begin
			rd_mux = {8'h00, ctl_r};
		end else if (sfr_addr == tcc_pkg::OFF_COUNT) begin
			rd_mux = count_r;
		end else if (sfr_addr == tcc_pkg::OFF_CAPCMP) begin
			rd_mux = capcmp_view;
		end else if (sfr_addr == tcc_pkg::OFF_CAP_A) begin
			rd_mux = cap_a_r;
		end else if (sfr_addr == tcc_pkg::OFF_CAP_B) begin
			rd_mux = cap_b_r;
		end else if (sfr_addr == tcc_pkg::OFF_EDGE_A) begin
			rd_mux = {8'h00, edge_a_r};
		end else if (sfr_addr == tcc_pkg::OFF_EDGE_B) begin
			rd_mux = {8'h00, edge_b_r};
		end else if (sfr_addr == tcc_pkg::OFF_SMP_A) begin
			rd_mux = {8'h00, smp_a_r};
		end else if (sfr_addr == tcc_pkg::OFF_SMP_B) begin
			rd_mux = {8'h00, smp_b_r};
		end
	end

	// ==================================================================
	// control registers; masks keep fixed bits at zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_r    <= tcc_pkg::RST_REG8;
			edge_a_r <= tcc_pkg::RST_REG8;
			edge_b_r <= tcc_pkg::RST_REG8;
			smp_a_r  <= tcc_pkg::RST_REG8;
			smp_b_r  <= tcc_pkg::RST_REG8;
		end else begin
			if (wr_ctl) ctl_r <= sfr_wdata[7:0] & tcc_pkg::CTL_MASK;
			if (wr_ea) edge_a_r <= sfr_wdata[7:0] & tcc_pkg::EDGE_A_MASK;
			if (wr_eb) edge_b_r <= sfr_wdata[7:0] & tcc_pkg::EDGE_B_MASK;
			if (wr_sa) smp_a_r <= sfr_wdata[7:0] & tcc_pkg::SMP_A_MASK;
			if (wr_sb) smp_b_r <= sfr_wdata[7:0] & tcc_pkg::SMP_B_MASK;
		end
	end

	// ==================================================================
	// counter, dividers and event history
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_r      <= tcc_pkg::RST_COUNT;
			pdiv_r       <= '0;
			sdiv_r       <= '0;
			start_pend_r <= 1'b0;
			match_hold_r <= 1'b0;
			eq_r         <= 1'b0;
			full_r       <= 1'b0;
			lvl_old_r    <= 3'h0;
		end else begin
			count_r      <= count_nxt;
			pdiv_r       <= ce ? pdiv_r + 1'b1 : '0;
			sdiv_r       <= sdiv_r + 1'b1;
			start_pend_r <= start_pend_nxt;
			match_hold_r <= match_hold_nxt;
			eq_r         <= eq_now;
			full_r       <= full_now;
			lvl_old_r    <= lvl;
		end
	end

	// capture storage has no reset value: contents undefined until first capture
	always_ff @(posedge sys_clk) begin
		if (wr_cmp) cmp_r <= sfr_wdata;
		if (!ccm && edge0) capcmp_r <= count_r;
		if (edge1) cap_a_r <= count_r;
		if (edge4) cap_b_r <= count_r;
	end

	// ==================================================================
	// interrupt pulses and read data, all registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vec0_r  <= 1'b0;
			ev1_r   <= 1'b0;
			ev4_r   <= 1'b0;
			ovf_r   <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			vec0_r  <= ccm ? match_pulse : edge0;
			ev1_r   <= edge1;
			ev4_r   <= edge4;
			ovf_r   <= ovf_pulse;
			rdata_r <= rd_mux;
		end
	end

	assign vec0_irq     = vec0_r;
	assign event1_irq   = ev1_r;
	assign event4_irq   = ev4_r;
	assign overflow_irq = ovf_r;
	assign sfr_rdata    = rdata_r;
endmodule : tcc_timer

// ### common/tcc_pkg.sv
// package: register map, field layout, reset values and divider masks for the timer unit
package tcc_pkg;
	// ==================================================================
	// register offsets (16-bit register port address)
	localparam logic [15:0] OFF_CTL      = 16'hFF7F; // counter_control_reg
	localparam logic [15:0] OFF_COUNT    = 16'hFF70; // main_counter, read only
	localparam logic [15:0] OFF_CAPCMP   = 16'hFF72; // capture_compare_reg
	localparam logic [15:0] OFF_CAP_A    = 16'hFF74; // capture_reg_a, read only
	localparam logic [15:0] OFF_CAP_B    = 16'hFF76; // capture_reg_b, read only
	localparam logic [15:0] OFF_EDGE_A   = 16'hFF78; // edge_mode_reg_a
	localparam logic [15:0] OFF_EDGE_B   = 16'hFF79; // edge_mode_reg_b
	localparam logic [15:0] OFF_SMP_A    = 16'hFF7A; // sampling_ctrl_reg_a
	localparam logic [15:0] OFF_SMP_B    = 16'hFF7B; // sampling_ctrl_reg_b

	// ==================================================================
	// counter_control_reg fields
	localparam int CTL_CE_BIT  = 7; // count_enable_bit
	localparam int CTL_CCM_BIT = 4; // compare_select_bit
	localparam int CTL_CLR_BIT = 3; // clear_select_bit
	localparam int CTL_PRM_LSB = 0; // prescale_sel_2..0 at bits 2..0

	// writable-bit masks; zero bits always read zero
	localparam logic [7:0] CTL_MASK    = 8'h9F;
	localparam logic [7:0] EDGE_A_MASK = 8'hFD;
	localparam logic [7:0] EDGE_B_MASK = 8'h0F;
	localparam logic [7:0] SMP_A_MASK  = 8'hFF;
	localparam logic [7:0] SMP_B_MASK  = 8'h03;

	// ==================================================================
	// field positions of the edge and sampling selects
	localparam int EDGE_EV0_LSB = 2; // edge_mode_reg_a [3:2]
	localparam int EDGE_EV1_LSB = 4; // edge_mode_reg_a [5:4]
	localparam int EDGE_EV4_LSB = 2; // edge_mode_reg_b [3:2]
	localparam int SMP_EV0_LSB  = 0; // sampling_ctrl_reg_a [1:0]
	localparam int SMP_EV1_LSB  = 2; // sampling_ctrl_reg_a [3:2]
	localparam int SMP_EV4_LSB  = 0; // sampling_ctrl_reg_b [1:0]

	// edge select encoding: 00 falling, 01 rising, 1x both
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;

	// ==================================================================
	// reset values
	localparam logic [7:0]  RST_REG8   = 8'h00;
	localparam logic [15:0] RST_COUNT  = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

	// ==================================================================
	// divider masks: a tick fires when the masked divider bits are all ones
	localparam logic [7:0] PRM_DIV4   = 8'h03;
	localparam logic [7:0] PRM_DIV8   = 8'h07;
	localparam logic [7:0] PRM_DIV16  = 8'h0F;
	localparam logic [7:0] PRM_DIV32  = 8'h1F;
	localparam logic [7:0] PRM_DIV64  = 8'h3F;
	localparam logic [7:0] PRM_DIV256 = 8'hFF;
	localparam int         SMP_TAPS   = 4; // agreeing samples needed
endpackage : tcc_pkg

// ### rtl/tcc_sampler.sv
// module: 4-point noise filter for one event input pin
`timescale 1ns/1ps
module tcc_sampler #(
	parameter int TAPS = tcc_pkg::SMP_TAPS
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pin_in,   // raw pin, asynchronous
	input  wire logic smp_en,   // one-cycle sampling strobe
	output logic      level     // accepted level
);
	// ==================================================================
	// synchroniser and sample history
	logic            sync1_r;   // first stage, read only by sync2_r
	logic            sync2_r;   // synchronised pin
	logic [TAPS-1:0] hist_r;    // last samples, newest in bit 0
	logic            level_r;   // accepted level
	logic [TAPS-1:0] hist_nxt;

	assign hist_nxt = {hist_r[TAPS-2:0], sync2_r};
	assign level    = level_r;

	// two flops before anything looks at the pin
	always_ff @(posedge sys_clk) begin
		sync1_r <= pin_in;
		sync2_r <= sync1_r;
	end

	// new level taken only when every sample agrees; a pulse of three
	// periods can never fill the history, so it is dropped as noise
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hist_r  <= '0;
			level_r <= 1'b0;
		end else if (smp_en) begin
			hist_r <= hist_nxt;
			if (&hist_nxt) begin
				level_r <= 1'b1;
			end else if (~|hist_nxt) begin
				level_r <= 1'b0;
			end
		end
	end
endmodule : tcc_sampler

// ### sim/tcc_pins_model.sv
// model: outside circuitry driving the three event pins of the timer
`timescale 1ns/1ps
module tcc_pins_model (
	input  wire logic sys_clk,
	output logic      event_input_0,
	output logic      event_input_1,
	output logic      event_input_4
);
	// ==================================================================
	// pin state, driven hard at all times, idle low
	logic [2:0] pin_r = 3'h0; // {event 4, event 1, event 0}
	assign {event_input_4, event_input_1, event_input_0} = pin_r;

	// ==================================================================
	// invert one pin for width clocks; widths of three sampling periods or less
	// are noise and only appear where a test asks for them
	task automatic pulse(input int idx, input int width);
		@(posedge sys_clk) #1;
		pin_r[idx] = ~pin_r[idx];
		repeat (width) @(posedge sys_clk);
		#1;
		pin_r[idx] = ~pin_r[idx];
	endtask : pulse
endmodule : tcc_pins_model

// ### sim/tcc_timer_props.sv
// checker: port-level properties of the capture/compare timer
`timescale 1ns/1ps
module tcc_timer_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [15:0] sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [15:0] sfr_wdata,
	input wire logic [15:0] sfr_rdata,
	input wire logic        event_input_0,
	input wire logic        event_input_1,
	input wire logic        event_input_4,
	input wire logic        vec0_irq,
	input wire logic        event1_irq,
	input wire logic        event4_irq,
	input wire logic        overflow_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==================================================================
	// helper state: control shadow and stability count of event pin 1
	logic [7:0] ctl_r;    // control value as written, masked
	logic [7:0] stab_r;   // clocks pin 1 has held, saturating
	logic [7:0] stab_nxt; // next stability count
	logic       pin1_r;   // pin 1 one clock ago
	assign stab_nxt = (event_input_1 != pin1_r) ? 8'h00 :
		(stab_r == 8'hFF) ? stab_r : stab_r + 8'h01;
	// shadow follows every control write, so mode is known at the ports
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_r <= 8'h00;
		end else if (sfr_wr && sfr_addr == tcc_pkg::OFF_CTL) begin
			ctl_r <= sfr_wdata[7:0] & tcc_pkg::CTL_MASK;
		end
	end
	// pin stability counter
	always_ff @(posedge sys_clk) begin
		pin1_r <= event_input_1;
		stab_r <= rst ? 8'h00 : stab_nxt;
	end
	// ==================================================================
	// properties
	property p_rst_clear;
		$fell(rst) |-> sfr_rdata == 16'h0000 && !vec0_irq && !event1_irq;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
	property p_ctl_mask;
		sfr_wr && sfr_addr == tcc_pkg::OFF_CTL ##1 !sfr_wr && sfr_addr == tcc_pkg::OFF_CTL
			|=> sfr_rdata[7:0] == ($past(sfr_wdata[7:0], 2) & tcc_pkg::CTL_MASK);
	endproperty
	a_ctl_mask: assert property (p_ctl_mask) else $error("control readback wrong");
	property p_edge_mask;
		sfr_wr && sfr_addr == tcc_pkg::OFF_EDGE_B ##1 !sfr_wr && sfr_addr == tcc_pkg::OFF_EDGE_B
			|=> sfr_rdata[7:0] == ($past(sfr_wdata[7:0], 2) & tcc_pkg::EDGE_B_MASK);
	endproperty
	a_edge_mask: assert property (p_edge_mask) else $error("edge mode readback wrong");
	property p_smp_mask;
		sfr_wr && sfr_addr == tcc_pkg::OFF_SMP_B ##1 !sfr_wr && sfr_addr == tcc_pkg::OFF_SMP_B
			|=> sfr_rdata[7:0] == ($past(sfr_wdata[7:0], 2) & tcc_pkg::SMP_B_MASK);
	endproperty
	a_smp_mask: assert property (p_smp_mask) else $error("sampling readback wrong");
	property p_stop_zero;
		sfr_wr && sfr_addr == tcc_pkg::OFF_CTL && !sfr_wdata[7] ##1 !sfr_wr
			##1 !sfr_wr && sfr_addr == tcc_pkg::OFF_COUNT |=> sfr_rdata == 16'h0000;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("counter not zero when stopped");
	property p_cmp_read;
		sfr_wr && sfr_addr == tcc_pkg::OFF_CAPCMP && ctl_r[tcc_pkg::CTL_CCM_BIT]
			##1 !sfr_wr && sfr_addr == tcc_pkg::OFF_CAPCMP |=> sfr_rdata == $past(sfr_wdata, 2);
	endproperty
	a_cmp_read: assert property (p_cmp_read) else $error("compare storage readback wrong");
	property p_filter;
		event1_irq |-> $past(stab_r, 4) >= 8'h08;
	endproperty
	a_filter: assert property (p_filter) else $error("short pin pulse accepted");
	property p_vec0_pulse;
		vec0_irq |=> !vec0_irq;
	endproperty
	a_vec0_pulse: assert property (p_vec0_pulse) else $error("shared vector pulse too long");
	property p_ev4_pulse;
		event4_irq |=> !event4_irq;
	endproperty
	a_ev4_pulse: assert property (p_ev4_pulse) else $error("event 4 pulse too long");
	// ==================================================================
	// cover the main scenarios
	c_cmp: cover property (vec0_irq && ctl_r[tcc_pkg::CTL_CCM_BIT]);
	c_ev1: cover property (event1_irq);
	c_ev4: cover property (event4_irq);
endmodule : tcc_timer_chk

bind tcc_timer tcc_timer_chk i_chk (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
	.sfr_rdata, .event_input_0, .event_input_1, .event_input_4, .vec0_irq,
	.event1_irq, .event4_irq, .overflow_irq);

// ### sim/test_timer_capture_compare_unit.sv
// testbench: registers, counting, compare and capture of the timer unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module test_timer_capture_compare_unit;
	typedef struct {string nm; logic [15:0] lo; logic [15:0] hi;} tcc_note_t;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] sfr_addr = 16'h0000;
	logic        sfr_wr = 1'b0;
	logic [15:0] sfr_wdata = 16'h0000;
	logic [15:0] sfr_rdata;
	logic        event_input_0, event_input_1, event_input_4;
	logic        vec0_irq, event1_irq, event4_irq, overflow_irq;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n_v0 = 0;
	int          n_e1 = 0;
	int          n_e4 = 0;
	int          n_ov = 0;                            // overflow pulses seen
	logic        rd_req = 1'b0;
	logic        rd_seen = 1'b0;
	tcc_note_t   notes[$];                            // pending read expectations
	int          div_tbl[8] = '{4, 8, 16, 32, 64, 256, 0, 0}; // 0: no ticks
	logic [15:0] a_tbl[5] = '{tcc_pkg::OFF_CTL, tcc_pkg::OFF_EDGE_A, tcc_pkg::OFF_EDGE_B,
		tcc_pkg::OFF_SMP_A, tcc_pkg::OFF_SMP_B};
	logic [7:0]  m_tbl[5] = '{tcc_pkg::CTL_MASK, tcc_pkg::EDGE_A_MASK, tcc_pkg::EDGE_B_MASK,
		tcc_pkg::SMP_A_MASK, tcc_pkg::SMP_B_MASK};

	always #50 sys_clk = ~sys_clk;

	tcc_timer i_dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
		.event_input_0, .event_input_1, .event_input_4, .vec0_irq, .event1_irq,
		.event4_irq, .overflow_irq);
	tcc_pins_model i_pins (.sys_clk, .event_input_0, .event_input_1, .event_input_4);

	// ==================================================================
	// watcher: counts pulses, checks each read one clock after its address
	always @(posedge sys_clk) begin
		tcc_note_t n;
		cyc <= cyc + 1;
		n_v0 <= n_v0 + int'(vec0_irq === 1'b1);
		n_e1 <= n_e1 + int'(event1_irq === 1'b1);
		n_e4 <= n_e4 + int'(event4_irq === 1'b1);
		n_ov <= n_ov + int'(overflow_irq === 1'b1);
		rd_seen <= rd_req;
		if (rd_seen) begin
			n = notes.pop_front();
			`CHK(n.nm, 1'b1, (sfr_rdata >= n.lo && sfr_rdata <= n.hi))
		end
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	// ==================================================================
	// register port tasks; one idle clock separates accesses
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk) #1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge sys_clk) #1;
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input string nm, input logic [15:0] a, lo, hi);
		@(posedge sys_clk) #1;
		sfr_addr = a;
		rd_req = 1'b1;
		notes.push_back('{nm, lo, hi});
		@(posedge sys_clk) #1;
		rd_req = 1'b0;
	endtask : rd
	// counter value t clocks after enabling at the fastest prescale
	function automatic logic [15:0] cval(input int t);
		return (t < 8) ? 16'h0000 : 16'(t / 4 - 1);
	endfunction : cval
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	// ==================================================================
	// main sequence
	initial begin
		int nv, n1, n4, s, ten;
		logic [15:0] rv, ce;
		void'($urandom(70356));
		repeat (8) @(posedge sys_clk);
		#1 rst = 1'b0;
		// reset values, fixed-zero bits, unmapped address
		for (int i = 0; i < 5; i++) begin
			rd("reset reg", a_tbl[i], 16'h0000, 16'h0000);
			wr(a_tbl[i], 16'h00FF);
			rd("masked reg", a_tbl[i], {8'h00, m_tbl[i]}, {8'h00, m_tbl[i]});
			wr(a_tbl[i], 16'h0000);
		end
		rd("reset count", tcc_pkg::OFF_COUNT, 16'h0000, 16'h0000);
		rd("unmapped", 16'h0000, 16'h0000, 16'h0000);
		$display("registers done");
		// codes 0-5: two ticks after the idle first tick, codes 6, 7: none; then stop
		for (int c = 0; c < 8; c++) begin
			ce = (div_tbl[c] != 0) ? 16'h0002 : 16'h0000;
			wr(tcc_pkg::OFF_CTL, 16'h0080 | 16'(c));
			repeat ((div_tbl[c] * 7) / 2 + 3 * int'(c > 5) - 1) @(posedge sys_clk);
			rd("prescale count", tcc_pkg::OFF_COUNT, ce, ce);
			// stop first: the next prescale code is only written while stopped
			wr(tcc_pkg::OFF_CTL, 16'h0000);
			rd("stopped count", tcc_pkg::OFF_COUNT, 16'h0000, 16'h0000);
		end
		// rewriting enable mid-count must not restart
		wr(tcc_pkg::OFF_CTL, 16'h0080);
		repeat (12) @(posedge sys_clk);
		wr(tcc_pkg::OFF_CTL, 16'h0080);
		repeat (14) @(posedge sys_clk);
		rd("no restart", tcc_pkg::OFF_COUNT, 16'h0006, 16'h0006);
		wr(tcc_pkg::OFF_CTL, 16'h0000);
		$display("counting done");
		// compare-clear interval with compare value 3
		wr(tcc_pkg::OFF_CAPCMP, 16'h0003);
		nv = n_v0;
		wr(tcc_pkg::OFF_CTL, 16'h0098);
		repeat (29) @(posedge sys_clk);
		rd("interval count", tcc_pkg::OFF_COUNT, 16'h0002, 16'h0002);
		repeat (6) @(posedge sys_clk);
		`CHK("compare irqs", 2, n_v0 - nv)
		rd("compare read", tcc_pkg::OFF_CAPCMP, 16'h0003, 16'h0003);
		wr(tcc_pkg::OFF_CTL, 16'h0000);
		// compare mode hides event 0; random compare value read back
		wr(tcc_pkg::OFF_EDGE_A, 16'h0014);
		wr(tcc_pkg::OFF_EDGE_B, 16'h0008);
		rv = 16'($urandom) | 16'h8000;
		wr(tcc_pkg::OFF_CTL, 16'h0095);
		wr(tcc_pkg::OFF_CAPCMP, rv);
		rd("random compare", tcc_pkg::OFF_CAPCMP, rv, rv);
		nv = n_v0;
		i_pins.pulse(0, 24);
		repeat (24) @(posedge sys_clk);
		`CHK("event 0 hidden", 0, n_v0 - nv)
		wr(tcc_pkg::OFF_CTL, 16'h0000);
		$display("compare done");
		// captures in free-running mode, short pulse rejected
		wr(tcc_pkg::OFF_CTL, 16'h0080);
		ten = cyc;
		n1 = n_e1;
		i_pins.pulse(1, 8);
		repeat (24 + $urandom_range(0, 7)) @(posedge sys_clk);
		`CHK("short pulse", 0, n_e1 - n1)
		s = cyc + 1;
		i_pins.pulse(1, 24);
		repeat (24) @(posedge sys_clk);
		`CHK("event 1 irq", 1, n_e1 - n1)
		rd("capture a", tcc_pkg::OFF_CAP_A, cval(s - ten + 12), cval(s - ten + 24));
		n4 = n_e4;
		s = cyc + 1;
		i_pins.pulse(2, 24);
		repeat (24) @(posedge sys_clk);
		`CHK("both edges", 2, n_e4 - n4)
		rd("capture b", tcc_pkg::OFF_CAP_B, cval(s - ten + 36), cval(s - ten + 48));
		nv = n_v0;
		s = cyc + 1;
		i_pins.pulse(0, 24);
		repeat (24) @(posedge sys_clk);
		`CHK("event 0 irq", 1, n_v0 - nv)
		rd("capture 0", tcc_pkg::OFF_CAPCMP, cval(s - ten + 12), cval(s - ten + 24));
		wr(tcc_pkg::OFF_CTL, 16'h0000);
		// event 1 valid on falling edges only, sampled at the /16 rate
		wr(tcc_pkg::OFF_EDGE_A, 16'h0004);
		wr(tcc_pkg::OFF_SMP_A, 16'h0004);
		n1 = n_e1;
		i_pins.pulse(1, 80);
		`CHK("rising ignored", 0, n_e1 - n1)
		repeat (80) @(posedge sys_clk);
		`CHK("falling edge", 1, n_e1 - n1)
		$display("capture done");
		// capture-clear interval: counter zeroed at the accepted edge
		wr(tcc_pkg::OFF_CTL, 16'h0088);
		repeat (40) @(posedge sys_clk);
		nv = n_v0;
		fork
			i_pins.pulse(0, 24);
		join_none
		for (int k = 0; k < 40 && n_v0 == nv; k++) @(posedge sys_clk);
		rd("capture clear", tcc_pkg::OFF_COUNT, 16'h0000, 16'h0001);
		repeat (30) @(posedge sys_clk);
		// the counter never nears FFFF in this run, so any overflow pulse is false
		`CHK("no overflow", 0, n_ov)
		$display("capture clear done");
		test_done();
	end
endmodule : test_timer_capture_compare_unit
